// file: chcb_regs.svh
// Register offsets, field positions and reset values of the clamp and blank generator
`ifndef CHCB_REGS_SVH
`define CHCB_REGS_SVH

`define CHCB_CMASK_BASE   12'h000
`define CHCB_PMASK_BASE   12'h020
`define CHCB_STATUS       12'h040
`define CHCB_SEQ_BASE     12'h100
`define CHCB_SEQ_SHIFT    7
`define CHCB_AREA_STRIDE  3

`define CHCB_W_CTL    5'h00
`define CHCB_W_CTOG   5'h01
`define CHCB_W_PTOG   5'h02
`define CHCB_W_EVEN1  5'h03
`define CHCB_W_RLEN   5'h09
`define CHCB_W_RCNT   5'h0A
`define CHCB_W_ODD1   5'h0B
`define CHCB_NWORD    17

`define CHCB_CTL_CLAMP_LVL 0
`define CHCB_CTL_PB_LVL    1
`define CHCB_CTL_PARK      2
`define CHCB_CTL_ALT_LSB   4
`define CHCB_SECOND_TOGGLE_LSB      16

`define CHCB_MASK_RST     12'hFFF
`define CHCB_PIX_TOG_RST  13'h1FFF
`define CHCB_HB_TOG_RST   13'h1FFD
`define CHCB_CTL_RST      32'h0000_0003
`define CHCB_RLEN_RST     32'h0000_0001
`define CHCB_CTL_MASK     32'h0000_0077
`define CHCB_TOGS_MASK    32'h1FFF_1FFF
`define CHCB_TOG_MASK     32'h0000_1FFF
`define CHCB_RCNT_MASK    32'h0000_00FF
`define CHCB_RESP_OKAY    2'h0
`define CHCB_RESP_SLVERR  2'h2

`endif

// file: chcb_pkg.sv
// Types of the clamp and blank generator
package chcb_pkg;
	typedef logic [12:0] chcb_pix_t;
	typedef logic [11:0] chcb_line_t;
	typedef enum logic [2:0] {
		CHCB_ALT_NONE = 3'h0,
		CHCB_ALT_ODD12 = 3'h1,
		CHCB_ALT_EVEN12 = 3'h2,
		CHCB_ALT_SPLIT = 3'h3
	} chcb_alt_t;
	typedef enum logic [2:0] {
		CHCB_RP_IDLE = 3'b001,
		CHCB_RP_RUN  = 3'b010,
		CHCB_RP_DONE = 3'b100
	} chcb_rp_t;
endpackage : chcb_pkg

// file: chcb_gen.sv
// Clamp, preblank and horizontal blanking pulse generator with AXI4-Lite registers
// What this block does
// - Clamp and preblank active low, level plus toggles
// - Toggles are 13-bit pixel positions, compared
// - Clamp/preblank pattern chosen per vertical sequence
// - Three clamp mask line ranges force inactive
// - Three preblank mask ranges, settings kept
// - Masks apply in every sequence
// - Mask registers reset 0xFFF, meaning disabled
// - Blanking window set by toggles only
// - Park level steers phases one and three during blanking, two and four held low
// - Blanking configuration chosen per vertical sequence
// - Six blanking toggles per line
// - Mode 0: even set every line
// - Mode 1: toggles 1-2 odd, 3-6 even
// - Mode 2: toggles 1-2 even, 3-6 odd
// - Mode 3: even set even, odd set odd
// - Odd set doubles as vertical pattern positions
// - Modes 4-7: start, end, length, repeats
// - Repeat length 13 bits, count 8 bits
// - Blanking toggles 13 bits wide
// - 13-bit pixel and 12-bit line counters
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "chcb_regs.svh"

module chcb_gen #(
	parameter int NUM_SEQ = 4,
	parameter int SEQ_W   = 2,
	parameter int AW      = 12
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [AW-1:0]     s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AW-1:0]     s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire chcb_pkg::chcb_pix_t  h_count,
	input  wire chcb_pkg::chcb_line_t v_count,
	input  wire logic [SEQ_W-1:0]  seq_sel,
	input  wire logic              h_phase_src,
	output logic                   optical_black_clamp_n,
	output logic                   preblank_pulse_n,
	output logic                   horizontal_blanking,
	output logic                   horiz_clock_phase_one,
	output logic                   horiz_clock_phase_two,
	output logic                   horiz_clock_phase_three,
	output logic                   horiz_clock_phase_four,
	output chcb_pkg::chcb_pix_t    vpattern_repeat_position,
	output chcb_pkg::chcb_pix_t    vpattern_hold_position,
	output chcb_pkg::chcb_pix_t    vpattern_continue_position,
	output logic                   vpattern_hold_available
);
	import chcb_pkg::*;

	logic [31:0]  seq_cfg_r [NUM_SEQ][`CHCB_NWORD];
	chcb_line_t   cmask_first_r [3];
	chcb_line_t   cmask_last_r [3];
	chcb_line_t   pmask_first_r [3];
	chcb_line_t   pmask_last_r [3];
	logic         aw_held_r, w_held_r, bvalid_r, rvalid_r;
	logic [AW-1:0] awaddr_r;
	logic [31:0]  wdata_r, rdata_r, rd_word;
	logic [3:0]   wstrb_r;
	logic [1:0]   bresp_r, rresp_r;
	logic         wr_go;
	logic         clamp_n_r, preblank_n_r, hblank_r;
	logic         h1_r, h2_r;
	chcb_pix_t    vrep_r, vhold_r, vcont_r;
	logic         hold_ok_r;

	function automatic logic [31:0] word_mask(input logic [4:0] idx);
		case (idx)
			`CHCB_W_CTL: word_mask = `CHCB_CTL_MASK;
			`CHCB_W_CTOG, `CHCB_W_PTOG: word_mask = `CHCB_TOGS_MASK;
			`CHCB_W_RCNT: word_mask = `CHCB_RCNT_MASK;
			default: word_mask = `CHCB_TOG_MASK;
		endcase
	endfunction : word_mask

	function automatic logic [31:0] word_reset(input logic [4:0] idx);
		case (idx)
			`CHCB_W_CTL: word_reset = `CHCB_CTL_RST;
			`CHCB_W_CTOG, `CHCB_W_PTOG:
				word_reset = {3'h0, `CHCB_PIX_TOG_RST, 3'h0, `CHCB_PIX_TOG_RST};
			`CHCB_W_RLEN: word_reset = `CHCB_RLEN_RST;
			`CHCB_W_RCNT: word_reset = 32'h0000_0000;
			default: word_reset = {19'h0, `CHCB_HB_TOG_RST};
		endcase
	endfunction : word_reset

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				old[8*b +: 8] = nw[8*b +: 8];
			end
		end
		merge = old;
	endfunction : merge

	// Pixel counter has reached a toggle position
	function automatic logic passed(input chcb_pix_t h, input chcb_pix_t t);
		passed = (h >= t);
	endfunction : passed

	function automatic logic in_area(input chcb_line_t v, input chcb_line_t first,
			input chcb_line_t last);
		in_area = (first != `CHCB_MASK_RST) && (v >= first) && (v <= last);
	endfunction : in_area

	// Sequence slot of an address, or the status/mask window below it
	function automatic logic addr_ok(input logic [AW-1:0] a);
		logic [AW-1:0] off;
		off = a - AW'(`CHCB_SEQ_BASE);
		if (a < AW'(`CHCB_SEQ_BASE)) begin
			addr_ok = (a[1:0] == 2'h0) && ((a[AW-1:3] < AW'(8) && a[4:3] != 2'h3
				&& a[AW-1:6] == '0) || a == AW'(`CHCB_STATUS));
		end else begin
			addr_ok = (a[1:0] == 2'h0) && (32'(off >> `CHCB_SEQ_SHIFT) < NUM_SEQ)
				&& (32'(off[6:2]) < `CHCB_NWORD);
		end
	endfunction : addr_ok

	// AXI4-Lite write channel, one write under way at a time
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready  = !w_held_r && !bvalid_r;
	assign wr_go         = aw_held_r && w_held_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `CHCB_RESP_OKAY;
			awaddr_r  <= '0;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= (addr_ok(awaddr_r) && awaddr_r != AW'(`CHCB_STATUS)) ?
					`CHCB_RESP_OKAY : `CHCB_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Line mask areas, common to every sequence
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int k = 0; k < 3; k++) begin
				cmask_first_r[k] <= `CHCB_MASK_RST;
				cmask_last_r[k]  <= `CHCB_MASK_RST;
				pmask_first_r[k] <= `CHCB_MASK_RST;
				pmask_last_r[k]  <= `CHCB_MASK_RST;
			end
		end else if (wr_go && addr_ok(awaddr_r) && awaddr_r < AW'(`CHCB_STATUS)) begin
			for (int k = 0; k < 3; k++) begin
				if (32'(awaddr_r[4:3]) == k) begin
					case ({awaddr_r[5], awaddr_r[2]})
						2'b00: cmask_first_r[k] <= 12'(merge({20'h0, cmask_first_r[k]},
							wdata_r, wstrb_r));
						2'b01: cmask_last_r[k] <= 12'(merge({20'h0, cmask_last_r[k]},
							wdata_r, wstrb_r));
						2'b10: pmask_first_r[k] <= 12'(merge({20'h0, pmask_first_r[k]},
							wdata_r, wstrb_r));
						default: pmask_last_r[k] <= 12'(merge({20'h0, pmask_last_r[k]},
							wdata_r, wstrb_r));
					endcase
				end
			end
		end
	end

	// Per-sequence pattern words
	always_ff @(posedge aclk) begin
		logic [AW-1:0] off;
		off = awaddr_r - AW'(`CHCB_SEQ_BASE);
		if (!aresetn) begin
			for (int s = 0; s < NUM_SEQ; s++) begin
				for (int w = 0; w < `CHCB_NWORD; w++) begin
					seq_cfg_r[s][w] <= word_reset(5'(w));
				end
			end
		end else if (wr_go && addr_ok(awaddr_r) && awaddr_r >= AW'(`CHCB_SEQ_BASE)) begin
			seq_cfg_r[32'(off >> `CHCB_SEQ_SHIFT)][off[6:2]] <=
				merge(seq_cfg_r[32'(off >> `CHCB_SEQ_SHIFT)][off[6:2]], wdata_r, wstrb_r)
				& word_mask(off[6:2]);
		end
	end

	// AXI4-Lite read channel
	always_comb begin
		logic [AW-1:0] off;
		off = s_axi_araddr - AW'(`CHCB_SEQ_BASE);
		rd_word = 32'h0000_0000;
		if (!addr_ok(s_axi_araddr)) begin
			rd_word = 32'h0000_0000;
		end else if (s_axi_araddr == AW'(`CHCB_STATUS)) begin
			rd_word = {4'h0, v_count, 8'(seq_sel), 5'h0, hblank_r, preblank_n_r, clamp_n_r};
		end else if (s_axi_araddr >= AW'(`CHCB_SEQ_BASE)) begin
			rd_word = seq_cfg_r[32'(off >> `CHCB_SEQ_SHIFT)][off[6:2]];
		end else begin
			case ({s_axi_araddr[5], s_axi_araddr[2]})
				2'b00: rd_word = {20'h0, cmask_first_r[s_axi_araddr[4:3]]};
				2'b01: rd_word = {20'h0, cmask_last_r[s_axi_araddr[4:3]]};
				2'b10: rd_word = {20'h0, pmask_first_r[s_axi_araddr[4:3]]};
				default: rd_word = {20'h0, pmask_last_r[s_axi_araddr[4:3]]};
			endcase
		end
	end

	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `CHCB_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= addr_ok(s_axi_araddr) ? `CHCB_RESP_OKAY : `CHCB_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// Active sequence configuration
	logic [SEQ_W-1:0] sel;
	logic [31:0]      ctl, ctog, ptog;
	chcb_pix_t        even_e [6];
	chcb_pix_t        odd_e [6];
	chcb_pix_t        rp_len, rp_pos_r, rp_pos_now;
	logic [7:0]       rp_cnt, rp_done_r;
	logic [2:0]       alt;
	logic             odd_line, cmasked, pmasked, clamp_lvl, pb_lvl;
	logic             tog_lvl, pat_lvl, window, rp_start, rp_active, blank_nxt;
	chcb_rp_t         rp_state_r;

	assign sel    = (32'(seq_sel) < NUM_SEQ) ? seq_sel : '0;
	assign ctl    = seq_cfg_r[sel][`CHCB_W_CTL];
	assign ctog   = seq_cfg_r[sel][`CHCB_W_CTOG];
	assign ptog   = seq_cfg_r[sel][`CHCB_W_PTOG];
	assign alt    = ctl[`CHCB_CTL_ALT_LSB +: 3];
	assign rp_len = seq_cfg_r[sel][`CHCB_W_RLEN][12:0];
	assign rp_cnt = seq_cfg_r[sel][`CHCB_W_RCNT][7:0];
	assign odd_line = v_count[0];

	always_comb begin
		for (int i = 0; i < 6; i++) begin
			even_e[i] = seq_cfg_r[sel][`CHCB_W_EVEN1 + i][12:0];
			odd_e[i]  = seq_cfg_r[sel][`CHCB_W_ODD1 + i][12:0];
		end
	end

	// Levels restart from the start level at pixel zero of every line
	always_comb begin
		cmasked = 1'b0;
		pmasked = 1'b0;
		for (int k = 0; k < 3; k++) begin
			cmasked = cmasked | in_area(v_count, cmask_first_r[k], cmask_last_r[k]);
			pmasked = pmasked | in_area(v_count, pmask_first_r[k], pmask_last_r[k]);
		end
		clamp_lvl = ctl[`CHCB_CTL_CLAMP_LVL] ^ passed(h_count, ctog[12:0])
			^ passed(h_count, ctog[`CHCB_SECOND_TOGGLE_LSB +: 13]);
		pb_lvl = ctl[`CHCB_CTL_PB_LVL] ^ passed(h_count, ptog[12:0])
			^ passed(h_count, ptog[`CHCB_SECOND_TOGGLE_LSB +: 13]);
	end

	// Toggle set chosen by alternation mode and line parity
	always_comb begin
		tog_lvl = 1'b0;
		case (alt)
			CHCB_ALT_NONE: begin
				for (int i = 0; i < 6; i++) tog_lvl ^= passed(h_count, even_e[i]);
			end
			CHCB_ALT_ODD12, CHCB_ALT_EVEN12: begin
				for (int i = 0; i < 6; i++) begin
					if ((i < 2) == (odd_line ^ (alt == CHCB_ALT_EVEN12))) begin
						tog_lvl ^= passed(h_count, even_e[i]);
					end
				end
			end
			CHCB_ALT_SPLIT: begin
				for (int i = 0; i < 6; i++) begin
					tog_lvl ^= passed(h_count, odd_line ? odd_e[i] : even_e[i]);
				end
			end
			default: tog_lvl = 1'b0;
		endcase
	end

	// Repeated pattern: toggles one to four measured within each pattern period
	assign window     = passed(h_count, even_e[4]) && !passed(h_count, even_e[5]);
	assign rp_start   = (h_count == even_e[4]) && (rp_cnt != 8'h00);
	assign rp_active  = (rp_state_r == CHCB_RP_RUN) || rp_start;
	assign rp_pos_now = (rp_state_r == CHCB_RP_RUN) ? rp_pos_r : 13'h0000;

	always_comb begin
		pat_lvl = 1'b0;
		for (int i = 0; i < 4; i++) pat_lvl ^= passed(rp_pos_now, even_e[i]);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || h_count == 13'h0000 || alt < 3'h4) begin
			rp_state_r <= CHCB_RP_IDLE;
			rp_pos_r   <= 13'h0000;
			rp_done_r  <= 8'h00;
		end else begin
			case (rp_state_r)
				CHCB_RP_IDLE, CHCB_RP_RUN: begin
					if (rp_active) begin
						rp_state_r <= CHCB_RP_RUN;
						rp_pos_r   <= 13'(rp_pos_now + 13'h0001);
						if (rp_pos_now + 13'h0001 >= rp_len) begin
							rp_pos_r  <= 13'h0000;
							rp_done_r <= 8'(rp_done_r + 8'h01);
							if (8'(rp_done_r + 8'h01) == rp_cnt) rp_state_r <= CHCB_RP_DONE;
						end
					end
				end
				CHCB_RP_DONE: rp_state_r <= CHCB_RP_DONE;
				default: rp_state_r <= CHCB_RP_IDLE;
			endcase
		end
	end

	// Blanking is a window from toggles alone, no start level
	assign blank_nxt = (alt >= 3'h4) ? (window ^ (rp_active && pat_lvl)) : tog_lvl;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clamp_n_r    <= 1'b1;
			preblank_n_r <= 1'b1;
			hblank_r     <= 1'b0;
		end else begin
			clamp_n_r    <= cmasked | clamp_lvl;
			preblank_n_r <= pmasked | pb_lvl;
			hblank_r     <= blank_nxt;
		end
	end

	// Phases parked during blanking
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			h1_r <= 1'b0;
			h2_r <= 1'b0;
		end else begin
			h1_r <= blank_nxt ? ctl[`CHCB_CTL_PARK] : h_phase_src;
			h2_r <= blank_nxt ? 1'b0 : !h_phase_src;
		end
	end

	// Odd set also serves vertical pattern repeat and hold
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vrep_r    <= `CHCB_HB_TOG_RST;
			vhold_r   <= `CHCB_HB_TOG_RST;
			vcont_r   <= `CHCB_HB_TOG_RST;
			hold_ok_r <= 1'b1;
		end else begin
			vrep_r    <= odd_e[0];
			vhold_r   <= odd_e[2];
			vcont_r   <= odd_e[3];
			hold_ok_r <= (alt != CHCB_ALT_SPLIT);
		end
	end

	assign optical_black_clamp_n      = clamp_n_r;
	assign preblank_pulse_n           = preblank_n_r;
	assign horizontal_blanking        = hblank_r;
	assign horiz_clock_phase_one      = h1_r;
	assign horiz_clock_phase_three    = h1_r;
	assign horiz_clock_phase_two      = h2_r;
	assign horiz_clock_phase_four     = h2_r;
	assign vpattern_repeat_position   = vrep_r;
	assign vpattern_hold_position     = vhold_r;
	assign vpattern_continue_position = vcont_r;
	assign vpattern_hold_available    = hold_ok_r;

endmodule : chcb_gen

// file: chcb_ccd_model.sv
// Line and field counters and raw horizontal phase seen by the generator
`timescale 1ns/1ps
module chcb_ccd_model #(
	parameter int LINE_LEN  = 64,
	parameter int FIELD_LEN = 8
) (
	input  wire logic           aclk,
	input  wire logic           aresetn,
	output chcb_pkg::chcb_pix_t  h_count,
	output chcb_pkg::chcb_line_t v_count,
	output logic                h_phase_src
);
	import chcb_pkg::*;
	// Short lines and fields keep the run brief
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			h_count <= '0;
			v_count <= '0;
		end else if (h_count == 13'(LINE_LEN - 1)) begin
			h_count <= '0;
			v_count <= (v_count == 12'(FIELD_LEN - 1)) ? '0 : v_count + 12'h001;
		end else begin
			h_count <= h_count + 13'h0001;
		end
	end
	always_ff @(posedge aclk) begin
		h_phase_src <= aresetn & ~h_phase_src;
	end
endmodule : chcb_ccd_model

// file: chcb_gen_assertions.sv
// Bus handshake and clock phase steering assertions
`timescale 1ns/1ps
module chcb_gen_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        h_phase_src,
	input wire logic        horizontal_blanking,
	input wire logic        horiz_clock_phase_one,
	input wire logic        horiz_clock_phase_two,
	input wire logic        horiz_clock_phase_three,
	input wire logic        horiz_clock_phase_four
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_park_low;
		horizontal_blanking |-> !horiz_clock_phase_two && !horiz_clock_phase_four;
	endproperty
	a_park_low: assert property (p_park_low) else $error("phase two or four high in blanking");
	property p_pairs;
		horiz_clock_phase_three == horiz_clock_phase_one &&
			horiz_clock_phase_four == horiz_clock_phase_two;
	endproperty
	a_pairs: assert property (p_pairs) else $error("phase pairs disagree");
	property p_pass;
		$past(aresetn) && !horizontal_blanking |->
			horiz_clock_phase_one == $past(h_phase_src) && horiz_clock_phase_two != $past(h_phase_src);
	endproperty
	a_pass: assert property (p_pass) else $error("phase not passed outside blanking");
	property p_bv_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bv_hold: assert property (p_bv_hold) else $error("write response dropped");
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write response repeated");
	property p_rv_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rv_hold: assert property (p_rv_hold) else $error("read data dropped");
	property p_ar_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
	property p_wr_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr_block: assert property (p_wr_block) else $error("write taken while response pending");
	property p_rd_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rd_block: assert property (p_rd_block) else $error("read taken while data pending");
endmodule : chcb_gen_assertions

bind chcb_gen chcb_gen_assertions u_chcb_gen_assertions (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.h_phase_src(h_phase_src), .horizontal_blanking(horizontal_blanking),
	.horiz_clock_phase_one(horiz_clock_phase_one), .horiz_clock_phase_two(horiz_clock_phase_two),
	.horiz_clock_phase_three(horiz_clock_phase_three),
	.horiz_clock_phase_four(horiz_clock_phase_four)
);

// file: chcb_gen_tb.sv
// Self-checking testbench of the clamp and blank generator
`timescale 1ns/1ps
`include "chcb_regs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module chcb_gen_tb;
	import chcb_pkg::*;
	localparam logic [1:0] OK  = `CHCB_RESP_OKAY;
	localparam logic [1:0] ERR = `CHCB_RESP_SLVERR;
	localparam logic [3:0] ALT_EXP [4] = '{4'hF, 4'h9, 4'h6, 4'h3};
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [1:0]  seq_sel = '0;
	chcb_pix_t   h_count, vpattern_repeat_position, vpattern_hold_position;
	chcb_pix_t   vpattern_continue_position;
	chcb_line_t  v_count;
	logic        h_phase_src, optical_black_clamp_n, preblank_pulse_n, horizontal_blanking;
	logic        horiz_clock_phase_one, horiz_clock_phase_two, horiz_clock_phase_three;
	logic        horiz_clock_phase_four, vpattern_hold_available;
	int          err_total = 0, tests_run = 0;
	int          ev [6] = '{40, 44, 46, 48, 50, 52};
	int          hp [6] = '{39, 40, 44, 46, 50, 52};
	logic [5:0]  hb_exp = 6'h1A;

	chcb_gen u_chcb_gen (.*);
	chcb_ccd_model u_chcb_ccd_model (.aclk(aclk), .aresetn(aresetn), .h_count(h_count),
		.v_count(v_count), .h_phase_src(h_phase_src));

	always #10 aclk = ~aclk;

	function automatic logic [11:0] sa(input int s, input int w);
		return 12'(`CHCB_SEQ_BASE + (s << `CHCB_SEQ_SHIFT) + 4 * w);
	endfunction : sa

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		repeat (50) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'h0;
		`CHK({s_axi_bvalid, s_axi_bresp}, {1'h1, er})
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		repeat (50) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'h0;
		`CHK({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'h1, er, d})
	endtask : axi_rd

	// Stop just after the edge that sampled this pixel and line
	task automatic at_px(input int v, input int h);
		bit hit;
		hit = 1'b0;
		repeat (2000) begin
			@(posedge aclk);
			if (h_count == 13'(h) && v_count == 12'(v)) begin
				hit = 1'b1;
				break;
			end
		end
		if (!hit) err_total++;
		#1;
	endtask : at_px

	task automatic chk_cl(input int v, input int h, input logic e);
		at_px(v, h);
		`CHK(optical_black_clamp_n, e)
	endtask : chk_cl

	task automatic chk_hb(input int v, input int h, input logic e);
		at_px(v, h);
		`CHK(horizontal_blanking, e)
	endtask : chk_hb

	task test_done;
		$display("Comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done

	initial begin
		#1_000_000;
		err_total++;
		test_done();
	end

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		for (int k = 0; k < 6; k++) begin
			axi_rd(12'(4 * k), 32'h0000_0FFF, OK);
			axi_rd(12'(32 + 4 * k), 32'h0000_0FFF, OK);
		end
		axi_rd(sa(0, 0), 32'h0000_0003, OK);
		axi_rd(sa(0, 1), 32'h1FFF_1FFF, OK);
		axi_rd(sa(0, `CHCB_W_EVEN1), 32'h0000_1FFD, OK);
		axi_rd(12'h018, 32'h0000_0000, ERR);
		axi_wr(`CHCB_STATUS, 32'h0000_0001, ERR);
		axi_wr(sa(0, 0), 32'hFFFF_FFFF, OK);
		axi_rd(sa(0, 0), 32'h0000_0077, OK);
		axi_wr(sa(0, `CHCB_W_RLEN), 32'hFFFF_FFFF, OK);
		axi_rd(sa(0, `CHCB_W_RLEN), 32'h0000_1FFF, OK);
		axi_wr(sa(0, `CHCB_W_RCNT), 32'hFFFF_FFFF, OK);
		axi_rd(sa(0, `CHCB_W_RCNT), 32'h0000_00FF, OK);
		$display("Test registers done");
		axi_wr(sa(0, 0), 32'h0000_0001, OK);
		axi_wr(sa(0, 1), 32'h0014_000A, OK);
		axi_wr(sa(0, 2), 32'h1FFF_001E, OK);
		chk_cl(0, 5, 1'h1);
		`CHK(preblank_pulse_n, 1'h0)
		chk_cl(0, 10, 1'h0);
		chk_cl(0, 20, 1'h1);
		at_px(0, 30);
		`CHK(preblank_pulse_n, 1'h1)
		chk_cl(1, 0, 1'h1);
		`CHK(preblank_pulse_n, 1'h0)
		$display("Test pulses done");
		axi_wr(sa(1, 1), 32'h1FFF_0000, OK);
		axi_wr(sa(1, 2), 32'h1FFF_0000, OK);
		@(posedge aclk);
		seq_sel <= 2'h1;
		chk_cl(2, 5, 1'h0);
		axi_wr(12'h008, 32'h0000_0003, OK);
		axi_wr(12'h00C, 32'h0000_0004, OK);
		axi_wr(12'h030, 32'h0000_0006, OK);
		axi_wr(12'h034, 32'h0000_0006, OK);
		chk_cl(3, 5, 1'h1);
		chk_cl(4, 5, 1'h1);
		chk_cl(5, 5, 1'h0);
		at_px(6, 5);
		`CHK(preblank_pulse_n, 1'h1)
		at_px(7, 5);
		`CHK(preblank_pulse_n, 1'h0)
		@(posedge aclk);
		seq_sel <= 2'h0;
		chk_cl(2, 15, 1'h0);
		chk_cl(3, 15, 1'h1);
		axi_wr(12'h008, 32'h0000_0FFF, OK);
		chk_cl(3, 15, 1'h0);
		$display("Test masks done");
		axi_wr(sa(0, 0), 32'h0000_0005, OK);
		for (int i = 0; i < 6; i++) begin
			axi_wr(sa(0, `CHCB_W_EVEN1 + i), 32'(ev[i]), OK);
			axi_wr(sa(0, `CHCB_W_ODD1 + i), (i < 2) ? 32'(10 + 2 * i) : 32'h1FFD, OK);
		end
		for (int i = 0; i < 6; i++) begin
			chk_hb(0, hp[i], hb_exp[i]);
		end
		at_px(1, 41);
		`CHK({horiz_clock_phase_one, horiz_clock_phase_two}, 2'h2)
		`CHK({horiz_clock_phase_three, horiz_clock_phase_four}, 2'h2)
		axi_wr(sa(0, 0), 32'h0000_0001, OK);
		at_px(2, 41);
		`CHK({horiz_clock_phase_one, horiz_clock_phase_three}, 2'h0)
		for (int m = 0; m < 4; m++) begin
			axi_wr(sa(0, 0), 32'(1 + 16 * m), OK);
			chk_hb(1, 41, ALT_EXP[m][3]);
			chk_hb(1, 47, ALT_EXP[m][2]);
			chk_hb(2, 41, ALT_EXP[m][1]);
			chk_hb(2, 47, ALT_EXP[m][0]);
			`CHK(vpattern_hold_available, (m != 3))
			`CHK(vpattern_repeat_position, 13'h000A)
		end
		chk_hb(3, 11, 1'h1);
		$display("Test alternation done");
		axi_wr(sa(0, `CHCB_W_RCNT), 32'h0000_0000, OK);
		for (int m = 4; m < 8; m++) begin
			axi_wr(sa(0, 0), 32'(1 + 16 * m), OK);
			chk_hb(1, 39, 1'h0);
			chk_hb(1, 50, 1'h1);
			chk_hb(1, 52, 1'h0);
		end
		$display("Test repeat modes done");
		test_done();
	end
endmodule : chcb_gen_tb
